// ### src/adc_tag_chain_readout.sv
// Digital core of a chainable serial converter: conversion control, result shifter, APB regs
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "adc_tag_chain_regs.svh"

module adc_tag_chain_readout
  import adc_tag_chain_pkg::*;
#(
  parameter int RES_WIDTH   = 16,
  parameter int CONV_CYCLES = `ATC_CONV_CYCLES,
  parameter int INT_HALF    = `ATC_INT_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Converter pins
  input  wire logic                 read_convert_n,
  input  wire logic                 chip_select_n,
  input  wire logic                 serial_clock_ext,
  input  wire logic                 cascade_in,
  input  wire logic                 clock_source_select,
  input  wire logic                 power_down_pin,
  output logic                      serial_data_out,
  output logic                      serial_data_oe,
  output logic                      serial_clock_out,
  output logic                      busy_n,
  // Analog core
  input  wire logic [RES_WIDTH-1:0] analog_result,
  output logic                      analog_power_down,
  // Interrupt
  output logic                      irq
);

  initial begin
    if (RES_WIDTH < 2 || RES_WIDTH > 31 || CONV_CYCLES < 2 || CONV_CYCLES > 65535 || INT_HALF < 1
        || INT_HALF > 255) begin
      $error("adc_tag_chain_readout: parameter out of range");
    end
  end

  localparam int NPIN = 6;
  localparam int SHW  = RES_WIDTH + 1;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: every outside level passes two flops first
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1;
  logic [NPIN-1:0] sync2;
  logic [NPIN-1:0] sync3;
  assign pin_raw = {power_down_pin, clock_source_select, cascade_in,
                    serial_clock_ext, chip_select_n, read_convert_n};

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
        end else begin
          sync1[g] <= pin_raw[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
        end
      end
    end
  endgenerate

  logic rc_fall;
  logic cs_act;
  logic sclk_rise;
  logic tag_s;
  logic ext_mode;
  logic pd_s;
  assign rc_fall   = sync3[0] & ~sync2[0];
  assign cs_act    = ~sync2[1];
  assign sclk_rise = sync2[2] & ~sync3[2];
  assign tag_s     = sync2[3];
  assign ext_mode  = sync2[4];
  assign pd_s      = sync2[5];

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Conversion control and result shifter
  conv_state_t     state;
  conv_state_t     next_state;
  logic [15:0]     conv_cnt;
  logic [15:0]     next_conv_cnt;
  logic [SHW-1:0]  shreg;
  logic [SHW-1:0]  next_shreg;
  logic [RES_WIDTH-1:0] result;
  logic [RES_WIDTH-1:0] next_result;
  logic [5:0]      shifted;
  logic [5:0]      next_shifted;
  logic [4:0]      int_left;
  logic [4:0]      next_int_left;
  logic [7:0]      div_cnt;
  logic [7:0]      next_div_cnt;
  logic            int_clk;
  logic            next_int_clk;
  logic            cascade_en;
  logic            conv_done;
  logic            read_done;
  logic            refused;
  logic            shift_now;
  logic            int_fall;

  assign int_fall  = int_clk && div_cnt == 8'(INT_HALF - 1);
  assign shift_now = cs_act && (ext_mode ? sclk_rise : int_fall);

  always_comb begin
    next_state    = state;
    next_conv_cnt = conv_cnt;
    next_shreg    = shreg;
    next_result   = result;
    next_shifted  = shifted;
    next_int_left = int_left;
    next_div_cnt  = div_cnt;
    next_int_clk  = int_clk;
    conv_done     = 1'b0;
    refused       = 1'b0;
    case (state)
      ST_IDLE: begin
        if (pd_s) begin
          next_state = ST_DOWN;
        end else if (rc_fall && cs_act) begin
          next_state    = ST_CONV;
          next_conv_cnt = 16'(CONV_CYCLES - 1);
        end
      end
      ST_CONV: begin
        if (rc_fall) begin
          refused = 1'b1;
        end
        if (conv_cnt == 16'h0000) begin
          next_state  = ST_IDLE;
          conv_done   = 1'b1;
          next_result = analog_result;
          // Own word, then the null slot, then whatever arrives on the cascade input
          next_shreg  = {analog_result, 1'b0};
          next_shifted = 6'h00;
          if (!ext_mode) begin
            next_int_left = 5'(RES_WIDTH);
            next_div_cnt  = 8'h00;
          end
        end else begin
          next_conv_cnt = conv_cnt - 16'h0001;
        end
      end
      ST_DOWN: begin
        // Result and shift position are left untouched so the old word can still be read
        if (rc_fall) begin
          refused = 1'b1;
        end
        if (!pd_s) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (shift_now && !conv_done) begin
      // Cascade bits only pass when the receiver owns the data clock
      next_shreg = {shreg[SHW-2:0], ext_mode & cascade_en & tag_s};
      if (shifted != 6'h3F) begin
        next_shifted = shifted + 6'h01;
      end
    end
    if (int_left != 5'h00 && !conv_done) begin
      if (div_cnt == 8'(INT_HALF - 1)) begin
        next_div_cnt = 8'h00;
        next_int_clk = ~int_clk;
        if (int_clk) begin
          next_int_left = int_left - 5'h01;
        end
      end else begin
        next_div_cnt = div_cnt + 8'h01;
      end
    end
  end

  assign read_done = shift_now && !conv_done && shifted == 6'(RES_WIDTH - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= ST_IDLE;
      conv_cnt <= 16'h0000;
      shreg    <= '0;
      result   <= '0;
      shifted  <= 6'h3F;
      int_left <= 5'h00;
      div_cnt  <= 8'h00;
      int_clk  <= 1'b0;
    end else begin
      state    <= next_state;
      conv_cnt <= next_conv_cnt;
      shreg    <= next_shreg;
      result   <= next_result;
      shifted  <= next_shifted;
      int_left <= next_int_left;
      div_cnt  <= next_div_cnt;
      int_clk  <= next_int_clk;
    end
  end

  assign serial_data_out   = shreg[SHW-1];
  assign serial_data_oe    = cs_act;
  assign serial_clock_out  = int_clk;
  assign busy_n            = (state != ST_CONV);
  assign analog_power_down = (state == ST_DOWN);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // APB registers and interrupt
  logic [31:0]               ctrl;
  logic [31:0]               next_ctrl;
  logic [`ATC_INT_WIDTH-1:0] int_status;
  logic [`ATC_INT_WIDTH-1:0] next_int_status;
  logic [`ATC_INT_WIDTH-1:0] int_mask;
  logic [`ATC_INT_WIDTH-1:0] next_int_mask;
  logic [31:0]               next_prdata;
  logic [`ATC_INT_WIDTH-1:0] events;
  logic                      wr;
  logic                      mapped;

  assign cascade_en = ctrl[`ATC_CTRL_CASCADE_EN];
  assign wr         = psel && penable && pwrite;
  assign mapped     = paddr == `ATC_CTRL_OFS || paddr == `ATC_STATUS_OFS
                   || paddr == `ATC_RESULT_OFS || paddr == `ATC_INT_STATUS_OFS
                   || paddr == `ATC_INT_MASK_OFS;
  assign events     = {refused, read_done, conv_done};

  always_comb begin
    next_ctrl       = ctrl;
    next_int_mask   = int_mask;
    next_prdata     = prdata;
    next_int_status = int_status;
    if (wr && paddr == `ATC_CTRL_OFS) begin
      next_ctrl = {31'h0000_0000, pwdata[`ATC_CTRL_CASCADE_EN]};
    end
    if (wr && paddr == `ATC_INT_MASK_OFS) begin
      next_int_mask = pwdata[`ATC_INT_WIDTH-1:0];
    end
    if (wr && paddr == `ATC_INT_STATUS_OFS) begin
      next_int_status = int_status & ~pwdata[`ATC_INT_WIDTH-1:0];
    end
    // A new event beats a clear in the same cycle
    next_int_status = next_int_status | events;
    if (psel && !penable) begin
      case (paddr)
        `ATC_CTRL_OFS:       next_prdata = ctrl;
        `ATC_STATUS_OFS:     next_prdata = {28'h000_0000, ext_mode, shifted >= 6'(RES_WIDTH),
                                            state == ST_DOWN, state == ST_CONV};
        `ATC_RESULT_OFS:     next_prdata = {{(32 - RES_WIDTH){1'b0}}, result};
        `ATC_INT_STATUS_OFS: next_prdata = {29'h0000_0000, int_status};
        `ATC_INT_MASK_OFS:   next_prdata = {29'h0000_0000, int_mask};
        default:             next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl       <= `ATC_CTRL_RESET;
      int_status <= '0;
      int_mask   <= '0;
      prdata     <= 32'h0000_0000;
    end else begin
      ctrl       <= next_ctrl;
      int_status <= next_int_status;
      int_mask   <= next_int_mask;
      prdata     <= next_prdata;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign irq     = |(int_status & int_mask);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Assertions
  no_cascade_int_a: assert property (@(posedge pclk) disable iff (!presetn)
    (shift_now && !conv_done && !ext_mode) |=> shreg[0] == 1'b0)
    else $error("cascade bit entered in internal clock mode");
  null_slot_a: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done |=> shreg[0] == 1'b0 && shreg[SHW-1:1] == $past(analog_result))
    else $error("result word not followed by null slot");
  cascade_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    (shift_now && !conv_done) |=> shreg[0] == $past(ext_mode & cascade_en & tag_s)
                               && shreg[SHW-1:1] == $past(shreg[SHW-2:0]))
    else $error("cascade bit not shifted in");
  pd_analog_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_IDLE && pd_s) |=> analog_power_down)
    else $error("power-down pin ignored");
  pd_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_DOWN && $past(state) == ST_DOWN) |-> $stable(result))
    else $error("result changed while powered down");
  busy_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy_n) |-> $past(conv_done) && result == $past(analog_result))
    else $error("busy released without a fresh result");
  conv_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_IDLE && next_state == ST_CONV) |=> !busy_n [*2])
    else $error("conversion shorter than expected");
  int_pulses_a: assert property (@(posedge pclk) disable iff (!presetn)
    (conv_done && !ext_mode) |=> int_left == 5'(RES_WIDTH))
    else $error("internal clock burst not started");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|events) |=> (int_status & $past(events)) == $past(events))
    else $error("event lost against clear");

endmodule

// ### common/adc_tag_chain_regs.svh
// Register offsets, field positions, reset values and timing counts of the tag-chain readout
// Operation
// - Cascade shifting only with external data clock
// - One null bit between chained result words
// - Power-down pin stops analog, keeps digital
// - Last result kept and shiftable when down
// - Clock source select: zero means internal
// - Busy output rising marks conversion end
`ifndef ADC_TAG_CHAIN_REGS_SVH
`define ADC_TAG_CHAIN_REGS_SVH

`define ATC_CTRL_OFS        12'h000
`define ATC_STATUS_OFS      12'h004
`define ATC_RESULT_OFS      12'h008
`define ATC_INT_STATUS_OFS  12'h00C
`define ATC_INT_MASK_OFS    12'h010

`define ATC_CTRL_CASCADE_EN 0
`define ATC_CTRL_RESET      32'h0000_0001

`define ATC_ST_BUSY         0
`define ATC_ST_DOWN         1
`define ATC_ST_SHIFTED      2
`define ATC_ST_EXT_MODE     3

`define ATC_INT_CONV_DONE   0
`define ATC_INT_READ_DONE   1
`define ATC_INT_REFUSED     2
`define ATC_INT_WIDTH       3

`define ATC_CLK_PERIOD_NS   50
`define ATC_CONV_TIME_NS    4000
`define ATC_CONV_CYCLES     ((`ATC_CONV_TIME_NS + `ATC_CLK_PERIOD_NS - 1) / `ATC_CLK_PERIOD_NS)
`define ATC_INT_HALF_CYCLES 2
`define ATC_PD_RECOVERY_NS  1000000

`endif

// ### common/adc_tag_chain_pkg.sv
// Types shared by the tag-chain readout
package adc_tag_chain_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_DOWN = 3'b100
  } conv_state_t;
endpackage

// ### test/adc_chain_receiver.sv
// Receiver and upstream converter model facing the chain pins
`timescale 1ns/1ps

module adc_chain_receiver (
  // Clock
  input  wire logic pclk,
  // Chain pins
  input  wire logic busy_n,
  input  wire logic serial_data_out,
  output logic      read_convert_n,
  output logic      serial_clock_ext,
  output logic      cascade_in
);
  logic [16:0] up;

  initial begin
    read_convert_n   = 1'b1;
    serial_clock_ext = 1'b0;
    up               = 17'h0;
  end

  // Upstream word with its null slot; all zero acts as a tied level
  assign cascade_in = up[16];

  task automatic convert();
    @(posedge pclk);
    // Shared and unstaggered: every converter samples at once
    read_convert_n <= 1'b0;
    repeat (4) @(posedge pclk);
    read_convert_n <= 1'b1;
  endtask

  // Clock idles low and runs only inside a read, 9 pclk per bit
  task automatic read(input int n, output logic [33:0] got);
    got = 34'h0;
    for (int i = 0; i < n; i++) begin
      got = {got[32:0], serial_data_out};
      @(posedge pclk);
      serial_clock_ext <= 1'b1;
      repeat (4) @(posedge pclk);
      serial_clock_ext <= 1'b0;
      up <= {up[15:0], 1'b0};
      repeat (4) @(posedge pclk);
    end
  endtask
endmodule

// ### test/adc_tag_chain_readout_tb.sv
// Self-checking bench for the tag-chain readout core
`timescale 1ns/1ps
`include "adc_tag_chain_regs.svh"

module adc_tag_chain_readout_tb;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic        pready, pslverr, err, bz, cs_n, sel, pwr_dn;
  logic        sdo, sclk_o, rc_n, sclk, casc, busy_n, apd, irq, oe;
  logic [15:0] ana, v;
  logic [33:0] got;
  int          n_mismatch, check_count, pulses;

  adc_tag_chain_readout #(.CONV_CYCLES(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .read_convert_n(rc_n),
    .chip_select_n(cs_n), .serial_clock_ext(sclk), .cascade_in(casc),
    .clock_source_select(sel), .power_down_pin(pwr_dn),
    .serial_data_out(sdo), .serial_data_oe(oe), .serial_clock_out(sclk_o),
    .busy_n(busy_n), .analog_result(ana), .analog_power_down(apd),
    .irq(irq)
  );

  adc_chain_receiver u_rx (
    .pclk(pclk), .busy_n(busy_n), .serial_data_out(sdo),
    .read_convert_n(rc_n), .serial_clock_ext(sclk), .cascade_in(casc)
  );

  always #25 pclk = ~pclk;
  always @(posedge sclk_o) pulses++;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input string w, input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", w, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic creg(input string w, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(w, {2'h0, rd}, {2'h0, e});
  endtask

  // Analog value is held through the whole conversion
  task automatic conv(input logic [15:0] val);
    ana <= val;
    u_rx.convert();
    bz = busy_n;
    while (busy_n !== 1'b1) @(posedge pclk);
    @(posedge pclk);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #3000000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    cs_n = 1'b0;
    sel = 1'b1;
    pwr_dn = 1'b0;
    ana = 16'h0;
    seed = 32'h0000_2584;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    creg("ctrl", `ATC_CTRL_OFS, `ATC_CTRL_RESET);
    creg("mask", `ATC_INT_MASK_OFS, 32'h0);
    creg("status", `ATC_STATUS_OFS, 32'hC);
    creg("unmapped", 12'h100, 32'h0);
    check("slverr", {33'h0, err}, 34'h1);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      v = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : seed[15:0];
      apb(1'b1, `ATC_INT_MASK_OFS, {31'h0, i[0]});
      conv(v);
      check("busy", {33'h0, bz}, 34'h0);
      check("irq", {33'h0, irq}, {33'h0, i[0]});
      creg("result", `ATC_RESULT_OFS, {16'h0, v});
      u_rx.up = {seed[31:16], 1'b0};
      u_rx.read(34, got);
      check("stream", got, {v, 1'b0, seed[31:16], 1'b0});
      check("words", {2'h0, got[33:18], got[16:1]}, {2'h0, v, seed[31:16]});
      creg("flags", `ATC_INT_STATUS_OFS, 32'h3);
      apb(1'b1, `ATC_INT_STATUS_OFS, 32'h3);
      creg("cleared", `ATC_INT_STATUS_OFS, 32'h0);
      check("irq off", {33'h0, irq}, 34'h0);
    end
    seed = xs(seed);
    v = seed[15:0];
    conv(v);
    u_rx.read(17, got);
    check("word17", got, {17'h0, v, 1'b0});
    $display("test chain done");
    sel <= 1'b0;
    repeat (4) @(posedge pclk);
    pulses = 0;
    conv(16'h5A5A);
    repeat (100) @(posedge pclk);
    check("pulses", 34'(pulses), 34'h10);
    sel <= 1'b1;
    apb(1'b1, `ATC_INT_STATUS_OFS, 32'h7);
    $display("test internal done");
    conv(16'hC3A5);
    u_rx.read(8, got);
    pwr_dn <= 1'b1;
    repeat (4) @(posedge pclk);
    check("down", {33'h0, apd}, 34'h1);
    creg("st down", `ATC_STATUS_OFS, 32'hA);
    conv(16'h0000);
    check("refused", {33'h0, bz}, 34'h1);
    creg("ref flag", `ATC_INT_STATUS_OFS, 32'h5);
    u_rx.read(8, got);
    check("kept", got, 34'hA5);
    creg("st shifted", `ATC_STATUS_OFS, 32'hE);
    pwr_dn <= 1'b0;
    repeat (6) @(posedge pclk);
    check("up", {33'h0, apd}, 34'h0);
    repeat (`ATC_PD_RECOVERY_NS / `ATC_CLK_PERIOD_NS) @(posedge pclk);
    cs_n <= 1'b1;
    repeat (4) @(posedge pclk);
    check("oe off", {33'h0, oe}, 34'h0);
    conv(16'h1234);
    check("cs idle", {33'h0, bz}, 34'h1);
    creg("cs result", `ATC_RESULT_OFS, 32'hC3A5);
    cs_n <= 1'b0;
    repeat (4) @(posedge pclk);
    check("oe on", {33'h0, oe}, 34'h1);
    conv(16'h1234);
    creg("after up", `ATC_RESULT_OFS, 32'h1234);
    $display("test power-down done");
    give_verdict();
  end
endmodule
